//--- hdl/tx_stream_regs.vh
`ifndef TX_STREAM_REGS_VH
`define TX_STREAM_REGS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0C

// Control register fields
`define CTRL_STREAM_ON 0
`define CTRL_CLEAR_FLAGS 1
`define CTRL_QUEUE_CLEAR 2
`define CTRL_RESET 1'h0

// Status register fields
`define ST_READING 0
`define ST_FULL 1
`define ST_EMPTY 2
`define ST_THREE_QTR 3
`define ST_ONE_QTR 4
`define ST_MID_BAND 5
`define ST_ERR_READER 6
`define ST_ERR_WRITER 7

// Interrupt status and mask fields
`define IRQ_ERR_READER 0
`define IRQ_ERR_WRITER 1
`define IRQ_OVERFLOW 2
`define IRQ_DRAINED_STOP 3
`define IRQ_WIDTH 4
`define IRQ_MASK_RESET 4'h0

// Queue sizing and thresholds
`define QUEUE_ADDR_BITS 17
`define PROG_EMPTY_WORDS 18'h181BE
`define NEARLY_DRAINED_WORDS 18'h00001

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/tx_stream_buffer.v
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tx_stream_regs.vh"

// Function
// - Buffer bytes into queue, deliver 16-bit words
// - Pack byte pairs, one write strobe each
// - Hold first byte until the second valid byte for pairing
// - Only valid bytes enter the queue
// - Start reading once threshold words stored
// - Keep reading until streaming is disabled or the queue is nearly drained
// - Stop at nearly drained, resume at threshold
// - Output valid only with queue data
// - Three-quarter level indicator
// - One-quarter level indicator
// - Mid band between quarter and three-quarter
// - Full on bit 0, empty on bit 1
// - Reader illegal state sets sticky flag
// - Writer illegal state sets own flag
// - Clear input clears illegal-state flags
module tx_stream_buffer #(
	parameter integer AW = `QUEUE_ADDR_BITS,
	parameter [AW:0] PROG_EMPTY_WORDS = `PROG_EMPTY_WORDS,
	parameter [AW:0] NEARLY_DRAINED_WORDS = `NEARLY_DRAINED_WORDS
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] stream_byte_in,
	input wire stream_byte_valid,
	output reg [15:0] word_out,
	output reg word_out_valid,
	output reg [1:0] queue_full_empty_flags,
	output reg level_three_quarter,
	output reg level_one_quarter,
	output reg level_mid_band,
	output reg [1:0] illegal_state_flag,
	output reg irq
);

	localparam integer DEPTH = 1 << AW;
	localparam [AW:0] L_DEPTH = {1'h1, {AW{1'b0}}};
	localparam [AW:0] L_QTR = {3'h1, {(AW-2){1'b0}}};
	localparam [AW:0] L_3QTR = {3'h3, {(AW-2){1'b0}}};
	localparam [1:0] W_FIRST = 2'h0;
	localparam [1:0] W_SECOND = 2'h1;
	localparam [1:0] R_IDLE = 2'h0;
	localparam [1:0] R_RUN = 2'h1;

	reg [15:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;

	reg tx_stream_on_q;
	reg clear_error_flags_q;
	reg queue_clear_req_q;
	reg queue_clear_q;
	reg on_meta_q;
	reg on_sync_q;
	reg [`IRQ_WIDTH-1:0] irq_status_q;
	reg [`IRQ_WIDTH-1:0] irq_mask_q;

	reg [1:0] wstate_q;
	reg [7:0] byte_hold_q;
	reg queue_write_strobe;
	reg [15:0] write_word;
	reg writer_err_ev;

	reg [1:0] rstate_q;
	reg reader_err_ev;
	reg drained_ev;
	reg read_go;

	reg [2:0] lvl_meta_q;
	reg [2:0] lvl_sync_q;

	reg aw_held_q;
	reg w_held_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;

	wire full = (count_q == L_DEPTH);
	wire empty = (count_q == {(AW+1){1'b0}});
	wire prog_empty = (count_q < PROG_EMPTY_WORDS);
	wire threshold = ~prog_empty;
	wire queue_nearly_drained = (count_q <= NEARLY_DRAINED_WORDS);
	wire do_write = queue_write_strobe & ~full;
	wire do_read = read_go & ~empty;
	wire rd_take = s_axi_arvalid & s_axi_arready;
	wire rd_irq = rd_take & (s_axi_araddr == `REG_IRQ_STATUS);
	wire [`IRQ_WIDTH-1:0] events = {drained_ev, queue_write_strobe & full, writer_err_ev,
		reader_err_ev};
	wire [31:0] status_word = {24'h000000, illegal_state_flag[1], illegal_state_flag[0],
		level_mid_band, level_one_quarter, level_three_quarter, empty, full, rstate_q == R_RUN};

	// Byte pairing machine
	always @* begin
		queue_write_strobe = 1'b0;
		write_word = {byte_hold_q, stream_byte_in};
		writer_err_ev = 1'b0;
		case (wstate_q)
			W_FIRST: begin
			end
			W_SECOND: begin
				queue_write_strobe = stream_byte_valid & tx_stream_on_q;
			end
			default: begin
				writer_err_ev = 1'b1;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn || queue_clear_q || !tx_stream_on_q) begin
			wstate_q <= W_FIRST;
			byte_hold_q <= 8'h00;
		end else begin
			case (wstate_q)
				W_FIRST: begin
					if (stream_byte_valid) begin
						byte_hold_q <= stream_byte_in;
						wstate_q <= W_SECOND;
					end
				end
				W_SECOND: begin
					if (stream_byte_valid) begin
						wstate_q <= W_FIRST;
					end
				end
				default: begin
					wstate_q <= W_FIRST;
				end
			endcase
		end
	end

	// Word queue storage
	always @(posedge aclk) begin
		if (do_write) begin
			mem[wr_ptr_q] <= write_word;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn || queue_clear_q) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (do_write) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (do_read) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (do_write && !do_read) begin
				count_q <= count_q + 1'b1;
			end else if (do_read && !do_write) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	// Read control machine
	always @* begin
		read_go = 1'b0;
		reader_err_ev = 1'b0;
		drained_ev = 1'b0;
		case (rstate_q)
			R_IDLE: begin
			end
			R_RUN: begin
				read_go = on_sync_q & ~queue_nearly_drained;
				drained_ev = on_sync_q & queue_nearly_drained;
			end
			default: begin
				reader_err_ev = 1'b1;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn || queue_clear_q) begin
			rstate_q <= R_IDLE;
		end else begin
			case (rstate_q)
				R_IDLE: begin
					if (threshold && on_sync_q) begin
						rstate_q <= R_RUN;
					end
				end
				R_RUN: begin
					if (!on_sync_q || queue_nearly_drained) begin
						rstate_q <= R_IDLE;
					end
				end
				default: begin
					rstate_q <= R_IDLE;
				end
			endcase
		end
	end

	// Output words and flags
	always @(posedge aclk) begin
		if (!aresetn) begin
			word_out <= 16'h0000;
			word_out_valid <= 1'b0;
			queue_full_empty_flags <= 2'h2;
			illegal_state_flag <= 2'h0;
			lvl_meta_q <= 3'h0;
			lvl_sync_q <= 3'h0;
			level_three_quarter <= 1'b0;
			level_one_quarter <= 1'b0;
			level_mid_band <= 1'b0;
		end else begin
			if (do_read) begin
				word_out <= mem[rd_ptr_q];
			end
			word_out_valid <= do_read;
			queue_full_empty_flags <= {empty, full};
			if (clear_error_flags_q) begin
				illegal_state_flag <= {writer_err_ev, reader_err_ev};
			end else begin
				illegal_state_flag <= illegal_state_flag | {writer_err_ev, reader_err_ev};
			end
			lvl_meta_q <= {count_q >= L_3QTR, count_q >= L_QTR,
				(count_q > L_QTR) && (count_q < L_3QTR)};
			lvl_sync_q <= lvl_meta_q;
			level_three_quarter <= lvl_sync_q[2];
			level_one_quarter <= lvl_sync_q[1];
			level_mid_band <= lvl_sync_q[0];
		end
	end

	// Control stage toward the read side
	always @(posedge aclk) begin
		if (!aresetn) begin
			on_meta_q <= 1'b0;
			on_sync_q <= 1'b0;
			queue_clear_q <= 1'b0;
		end else begin
			on_meta_q <= tx_stream_on_q;
			on_sync_q <= on_meta_q;
			queue_clear_q <= queue_clear_req_q;
		end
	end

	// Bus write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			tx_stream_on_q <= `CTRL_RESET;
			clear_error_flags_q <= 1'b0;
			queue_clear_req_q <= 1'b0;
			irq_mask_q <= `IRQ_MASK_RESET;
		end else begin
			clear_error_flags_q <= 1'b0;
			queue_clear_req_q <= 1'b0;
			s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (aw_held_q && w_held_q && !s_axi_bvalid) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (aw_addr_q)
					`REG_CTRL: begin
						if (w_strb_q[0]) begin
							tx_stream_on_q <= w_data_q[`CTRL_STREAM_ON];
							clear_error_flags_q <= w_data_q[`CTRL_CLEAR_FLAGS];
							queue_clear_req_q <= w_data_q[`CTRL_QUEUE_CLEAR];
						end
					end
					`REG_IRQ_MASK: begin
						if (w_strb_q[0]) begin
							irq_mask_q <= w_data_q[`IRQ_WIDTH-1:0];
						end
					end
					`REG_STATUS, `REG_IRQ_STATUS: begin
					end
					default: begin
						s_axi_bresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bus read channel and interrupt status
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
			irq_status_q <= {`IRQ_WIDTH{1'b0}};
			irq <= 1'b0;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr)
					`REG_CTRL: s_axi_rdata <= {31'h00000000, tx_stream_on_q};
					`REG_STATUS: s_axi_rdata <= status_word;
					`REG_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status_q};
					`REG_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_q};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			irq_status_q <= (rd_irq ? {`IRQ_WIDTH{1'b0}} : irq_status_q) | events;
			irq <= |(((rd_irq ? {`IRQ_WIDTH{1'b0}} : irq_status_q) | events) & irq_mask_q);
		end
	end

endmodule // tx_stream_buffer

`default_nettype wire

//--- tb/tx_stream_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tx_stream_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic word_out_valid,
	input wire logic [1:0] queue_full_empty_flags,
	input wire logic level_three_quarter,
	input wire logic level_one_quarter,
	input wire logic level_mid_band,
	input wire logic [1:0] illegal_state_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence run_burst;
		word_out_valid [*4];
	endsequence
	sequence drained_long;
		queue_full_empty_flags[1] [*4];
	endsequence
	flags_legal_a: assert property (queue_full_empty_flags != 2'h3)
		else $error("full and empty together");
	quarter_order_a: assert property (level_three_quarter |-> level_one_quarter)
		else $error("three quarter without one quarter");
	mid_band_a: assert property (level_mid_band |-> level_one_quarter && !level_three_quarter)
		else $error("mid band outside its range");
	empty_levels_a: assert property (drained_long |-> !level_one_quarter && !level_mid_band)
		else $error("level set on empty queue");
	no_illegal_a: assert property (illegal_state_flag == 2'h0)
		else $error("illegal state flag set");
	read_burst_a: assert property ($rose(word_out_valid) |-> run_burst)
		else $error("output words not continuous");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
		else $error("no write response");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during read answer");
endmodule // tx_stream_monitor
bind tx_stream_buffer tx_stream_monitor u_tx_stream_monitor (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.word_out_valid, .queue_full_empty_flags, .level_three_quarter, .level_one_quarter,
	.level_mid_band, .illegal_state_flag);
`default_nettype wire

//--- tb/stream_src.sv
`timescale 1ns/1ps
`default_nettype none
module stream_src (
	input wire logic aclk,
	output logic [7:0] stream_byte_in,
	output logic stream_byte_valid
);
	logic [7:0] nb = 8'h00;
	initial begin
		stream_byte_in = 8'hFF;
		stream_byte_valid = 1'b0;
	end
	// Payload bytes carry a running count; idle cycles show a changed byte
	task send(input integer n, input integer gap);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				@(posedge aclk);
				stream_byte_in <= nb;
				stream_byte_valid <= 1'b1;
				nb = nb + 8'h01;
				if (gap != 0) begin
					@(posedge aclk);
					stream_byte_in <= ~stream_byte_in;
					stream_byte_valid <= 1'b0;
				end
			end
			@(posedge aclk);
			stream_byte_in <= ~stream_byte_in;
			stream_byte_valid <= 1'b0;
		end
	endtask
endmodule // stream_src
`default_nettype wire

//--- tb/tb_tx_stream_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tx_stream_buffer;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic word_out_valid, level_three_quarter, level_one_quarter, level_mid_band, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, queue_full_empty_flags, illegal_state_flag;
	logic [31:0] s_axi_rdata;
	logic [15:0] word_out;
	logic [7:0] stream_byte_in;
	logic stream_byte_valid;
	integer n_fail = 0, checks_done = 0, nw = 0, i;
	tx_stream_buffer #(.AW(4), .PROG_EMPTY_WORDS(5'h0E), .NEARLY_DRAINED_WORDS(5'h01))
	u_tx_stream_buffer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stream_byte_in, .stream_byte_valid,
		.word_out, .word_out_valid, .queue_full_empty_flags, .level_three_quarter,
		.level_one_quarter, .level_mid_band, .illegal_state_flag, .irq);
	stream_src u_stream_src (.aclk, .stream_byte_in, .stream_byte_valid);
	initial forever #50 aclk = ~aclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done = checks_done + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task give_verdict;
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One bus transfer; write when w is high, d is write data or expected read data
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		integer k;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_araddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= w;
			s_axi_wvalid <= w;
			s_axi_bready <= w;
			s_axi_arvalid <= !w;
			s_axi_rready <= !w;
			for (k = 0; k < 40; k = k + 1) begin
				@(posedge aclk);
				if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
				if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
				if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
				if (s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1) break;
			end
			s_axi_bready <= 1'b0;
			s_axi_rready <= 1'b0;
			chk(k < 40, 32'h1);
			if (k == 40) give_verdict;
			chk(w ? s_axi_bresp : s_axi_rresp, r);
			if (!w) chk(s_axi_rdata, d);
		end
	endtask
	task lvl(input logic [31:0] e);
		repeat (4) @(posedge aclk);
		acc(1'b0, 8'h04, e, 2'h0);
	endtask
	// Next byte pair, first byte high; six bytes sent while off are dropped
	always @(posedge aclk) begin
		if (word_out_valid === 1'b1) begin
			chk(word_out, {nw[6:0] + 7'h03, 1'b0, nw[6:0] + 7'h03, 1'b1});
			nw = nw + 1;
		end
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		acc(1'b0, 8'h00, 32'h0, 2'h0);
		acc(1'b0, 8'h04, 32'h4, 2'h0);
		chk(queue_full_empty_flags, 32'h2);
		acc(1'b0, 8'h0C, 32'h0, 2'h0);
		acc(1'b0, 8'h10, 32'h0, 2'h2);
		acc(1'b1, 8'h10, 32'h1, 2'h2);
		u_stream_src.send(6, 0);
		lvl(32'h4);
		acc(1'b1, 8'h00, 32'h3, 2'h0);
		u_stream_src.send(4, 1);
		lvl(32'h0);
		u_stream_src.send(8, 0);
		lvl(32'h30);
		u_stream_src.send(14, 1);
		lvl(32'h18);
		chk(nw, 32'h0);
		u_stream_src.send(2, 0);
		for (i = 0; i < 300 && nw < 13; i = i + 1) @(posedge aclk);
		if (nw < 13) begin
			chk(nw, 32'hD);
			give_verdict;
		end
		repeat (8) @(posedge aclk);
		chk(nw, 32'hD);
		chk(irq, 32'h0);
		acc(1'b1, 8'h0C, 32'h8, 2'h0);
		@(posedge aclk);
		chk(irq, 32'h1);
		acc(1'b0, 8'h08, 32'h8, 2'h0);
		@(posedge aclk);
		chk(irq, 32'h0);
		acc(1'b0, 8'h08, 32'h0, 2'h0);
		lvl(32'h0);
		chk(queue_full_empty_flags, 32'h0);
		acc(1'b1, 8'h00, 32'h5, 2'h0);
		lvl(32'h4);
		chk(queue_full_empty_flags, 32'h2);
		chk(nw, 32'hD);
		give_verdict;
	end
endmodule // tb_tx_stream_buffer
`default_nettype wire
